// ### design/pcs_pkg.sv
// package for the clock synthesis control block: register map, fields, constants
package pcs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_PHASE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  // ctrl field positions
  localparam int CTRL_FB_SEL_LSB = 0;
  localparam int CTRL_SEC_SEL = 2;
  localparam int CTRL_DYN_MODE = 3;
  localparam int CTRL_CASCADE = 4;
  // feedback sources
  localparam logic [1:0] FB_PRIMARY = 2'h0;
  localparam logic [1:0] FB_SHIFTED = 2'h1;
  localparam logic [1:0] FB_USER = 2'h2;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [7:0] DIV_IN_RESET = 8'h00;
  localparam logic [7:0] DIV_FB_RESET = 8'h00;
  localparam logic [7:0] DIV_OUT_RESET = 8'h00;
  localparam logic [7:0] DIV_SEC_RESET = 8'h01;
  localparam logic [3:0] FINE_RESET = 4'h0;
  localparam logic [3:0] COARSE_RESET = 4'h0;
  // fine delay: up to 16 steps of nominal 125 ps; coarse 22.5 degree steps
  localparam int FINE_STEPS = 16;
  localparam int FINE_STEP_PS = 125;
  localparam int COARSE_STEPS = 16;
  // lock time, in microseconds, and derived cycle count at 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int LOCK_TIME_US = 100;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  // interrupt bit positions
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_W = 2;

  typedef struct packed {
    logic [7:0] in_div;
    logic [7:0] fb_div;
    logic [7:0] out_div;
    logic [7:0] sec_div;
  } pcs_div_t;

  typedef struct packed {
    logic [3:0] fine;
    logic [3:0] coarse;
  } pcs_phase_t;

  typedef enum logic [2:0] {
    ST_UNLOCKED = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_LOCKED = 3'b100
  } pcs_lock_st_t;

  typedef struct packed {
    logic [4:0] ctrl;
    pcs_div_t div;
    pcs_phase_t phase_cfg;
    pcs_phase_t phase_dyn_s1;
    pcs_phase_t phase_dyn;
    pcs_phase_t phase_act;
    logic ref_s1;
    logic ref_s2;
    logic ref_d;
    logic fb_s1;
    logic fb_s2;
    logic fb_d;
    logic [7:0] in_cnt;
    logic ref_tick;
    logic [7:0] fbd_cnt;
    logic fb_tick;
    logic [7:0] vco_cnt;
    logic [7:0] op_cnt;
    logic primary;
    logic [3:0] ph_pipe;
    logic [15:0] shift_line;
    logic shifted;
    logic [7:0] sec_cnt;
    logic sec_a;
    logic sec_b;
    logic sec_src_d;
    pcs_lock_st_t lock_st;
    logic [31:0] lock_cnt;
    logic lock;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cascade_out;
  } pcs_state_t;
endpackage : pcs_pkg

// ### design/pcs_pll_ctrl.sv
// clock synthesis control: dividers, phase adjust, lock tracking, apb registers
`timescale 1ns/1ns
`default_nettype none

// Operation
// - reference clock passes through the input divider before phase compare
// - feedback divider, fed by primary, shifted or user clock, sets multiplication
// - lock flag rises once reference and feedback agree in frequency and phase
// - dynamic phase changes may drop lock until lock time elapses
// - primary output is the oscillator divided by the output divider
// - shifted output phase set statically or from fabric at run time
// - secondary divider takes primary or shifted output for slower clocks
// - primary, both secondary and shifted outputs drive distribution
// - fine delay inserts up to sixteen nominal 125 ps steps
// - coarse phase moves both edges in 22.5 degree steps
// - step counts come from static config or fabric inputs
// - primary or shifted output may be selected as reference for a cascaded pll or dll
module pcs_pll_ctrl #(
  parameter int LOCK_WAIT = pcs_pkg::LOCK_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock pins
  input wire logic reference_clock_in,
  input wire logic feedback_clock_in,
  input wire logic osc_in,
  // fabric dynamic phase
  input wire logic [3:0] dyn_fine_steps,
  input wire logic [3:0] dyn_coarse_steps,
  // outputs
  output logic primary_clock_out,
  output logic phase_shifted_clock_out,
  output logic secondary_divided_clock_out,
  output logic secondary_divided_clock_out_b,
  output logic cascade_clock_out,
  output logic lock,
  output logic irq
);
  pcs_pkg::pcs_state_t s;
  pcs_pkg::pcs_state_t next_s;
  logic wr;
  logic rd;
  logic cfg_change;
  logic fb_sel_bit;
  logic sec_src;
  localparam int IRQ_W_M = pcs_pkg::IRQ_W - 1;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    next_s = s;
    cfg_change = 1'b0;
    // oscillator-domain samples: every pin input except osc_in goes through two flops
    next_s.ref_s1 = reference_clock_in;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_d = s.ref_s2;
    next_s.phase_dyn_s1 = {dyn_fine_steps, dyn_coarse_steps};
    next_s.phase_dyn = s.phase_dyn_s1;
    // user pin synchronised ahead of the select, so it lines up with the reference path
    next_s.fb_s1 = feedback_clock_in;
    next_s.fb_s2 = s.fb_s1;
    case (s.ctrl[pcs_pkg::CTRL_FB_SEL_LSB +: 2])
      pcs_pkg::FB_PRIMARY: fb_sel_bit = s.primary;
      pcs_pkg::FB_SHIFTED: fb_sel_bit = s.shifted;
      default: fb_sel_bit = s.fb_s2;
    endcase
    next_s.fb_d = fb_sel_bit;
    // input divider counts each reference rising edge, ticks when the count reaches in_div
    next_s.ref_tick = 1'b0;
    if (s.ref_s2 && !s.ref_d) begin
      if (s.in_cnt >= s.div.in_div) begin
        next_s.in_cnt = 8'h00;
        next_s.ref_tick = 1'b1;
      end else begin
        next_s.in_cnt = s.in_cnt + 8'h01;
      end
    end
    next_s.fb_tick = 1'b0;
    if (fb_sel_bit && !s.fb_d) begin
      if (s.fbd_cnt >= s.div.fb_div) begin
        next_s.fbd_cnt = 8'h00;
        next_s.fb_tick = 1'b1;
      end else begin
        next_s.fbd_cnt = s.fbd_cnt + 8'h01;
      end
    end
    // primary output: oscillator edges divided, toggle per terminal count
    if (s.op_cnt >= s.div.out_div) begin
      next_s.op_cnt = 8'h00;
      next_s.primary = !s.primary;
    end else begin
      next_s.op_cnt = s.op_cnt + 8'h01;
    end
    // phase selection: static config or fabric values
    if (s.ctrl[pcs_pkg::CTRL_DYN_MODE]) begin
      next_s.phase_act = s.phase_dyn;
    end else begin
      next_s.phase_act = s.phase_cfg;
    end
    if (next_s.phase_act != s.phase_act) begin
      cfg_change = 1'b1;
    end
    // shifted output: coarse step picks a tap of the delay line (both edges move)
    next_s.shift_line = {s.shift_line[14:0], s.primary};
    next_s.ph_pipe = s.phase_act.fine;
    next_s.shifted = s.shift_line[s.phase_act.coarse];
    // secondary divider from primary or shifted, fine delay taps the line
    sec_src = s.ctrl[pcs_pkg::CTRL_SEC_SEL] ? s.shifted : s.primary;
    next_s.sec_src_d = sec_src;
    if (sec_src && !s.sec_src_d) begin
      if (s.sec_cnt >= s.div.sec_div) begin
        next_s.sec_cnt = 8'h00;
        next_s.sec_a = !s.sec_a;
      end else begin
        next_s.sec_cnt = s.sec_cnt + 8'h01;
      end
    end
    // fine delay modelled as one tap per step along the line, independent of the coarse tap
    next_s.sec_b = s.shift_line[s.ph_pipe] ^ s.sec_a;
    next_s.cascade_out = s.ctrl[pcs_pkg::CTRL_CASCADE] ? s.shifted : s.primary;
    // apb registers
    next_s.pready = psel && !penable;
    next_s.pslverr = 1'b0;
    if (rd) begin
      case (paddr)
        pcs_pkg::ADDR_CTRL: next_s.prdata = {27'h0000000, s.ctrl};
        pcs_pkg::ADDR_DIV: next_s.prdata = s.div;
        pcs_pkg::ADDR_PHASE: next_s.prdata = {24'h000000, s.phase_cfg};
        pcs_pkg::ADDR_STATUS: next_s.prdata = {20'h00000, s.phase_act, 3'h0, s.lock};
        pcs_pkg::ADDR_IRQ_STAT: next_s.prdata = {30'h00000000, s.irq_stat};
        pcs_pkg::ADDR_IRQ_EN: next_s.prdata = {30'h00000000, s.irq_en};
        pcs_pkg::ADDR_IRQ_CLR: next_s.prdata = 32'h00000000;
        default: begin
          next_s.prdata = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      next_s.prdata = 32'h00000000;
      if (!(paddr inside {pcs_pkg::ADDR_CTRL, pcs_pkg::ADDR_DIV, pcs_pkg::ADDR_PHASE,
                          pcs_pkg::ADDR_STATUS, pcs_pkg::ADDR_IRQ_STAT, pcs_pkg::ADDR_IRQ_EN,
                          pcs_pkg::ADDR_IRQ_CLR})) begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr && s.pready) begin
      case (paddr)
        pcs_pkg::ADDR_CTRL: begin
          if (pwdata[4:0] != s.ctrl) cfg_change = 1'b1;
          next_s.ctrl = pwdata[4:0];
        end
        pcs_pkg::ADDR_DIV: begin
          cfg_change = 1'b1;
          next_s.div = pwdata;
        end
        pcs_pkg::ADDR_PHASE: next_s.phase_cfg = pwdata[7:0];
        pcs_pkg::ADDR_IRQ_EN: next_s.irq_en = pwdata[IRQ_W_M:0];
        default: begin
        end
      endcase
    end
    // lock tracking: ref and feedback ticks must coincide for lock wait cycles
    next_s.lock = 1'b0;
    case (s.lock_st)
      pcs_pkg::ST_UNLOCKED: begin
        next_s.lock_cnt = 32'h00000000;
        if (s.ref_tick && s.fb_tick) next_s.lock_st = pcs_pkg::ST_ACQUIRE;
      end
      pcs_pkg::ST_ACQUIRE: begin
        if (s.ref_tick != s.fb_tick) begin
          next_s.lock_st = pcs_pkg::ST_UNLOCKED;
        end else if (s.lock_cnt >= LOCK_WAIT[31:0] - 32'h00000001) begin
          next_s.lock_st = pcs_pkg::ST_LOCKED;
        end else begin
          next_s.lock_cnt = s.lock_cnt + 32'h00000001;
        end
      end
      pcs_pkg::ST_LOCKED: begin
        next_s.lock = 1'b1;
        if (s.ref_tick != s.fb_tick) next_s.lock_st = pcs_pkg::ST_UNLOCKED;
      end
      default: next_s.lock_st = pcs_pkg::ST_UNLOCKED;
    endcase
    if (cfg_change) begin
      next_s.lock_st = pcs_pkg::ST_UNLOCKED;
      next_s.lock = 1'b0;
    end
    // sticky events; set wins over clear
    if (wr && s.pready && paddr == pcs_pkg::ADDR_IRQ_CLR) begin
      next_s.irq_stat = s.irq_stat & ~pwdata[IRQ_W_M:0];
    end
    if (next_s.lock && !s.lock) next_s.irq_stat[pcs_pkg::IRQ_LOCK_GAIN] = 1'b1;
    if (!next_s.lock && s.lock) next_s.irq_stat[pcs_pkg::IRQ_LOCK_LOSS] = 1'b1;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
  end

  // the oscillator itself is analog; pclk stands in for it and osc_in is left unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= pcs_pkg::CTRL_RESET;
      s.div <= {pcs_pkg::DIV_IN_RESET, pcs_pkg::DIV_FB_RESET, pcs_pkg::DIV_OUT_RESET, pcs_pkg::DIV_SEC_RESET};
      s.phase_cfg <= {pcs_pkg::FINE_RESET, pcs_pkg::COARSE_RESET};
      s.lock_st <= pcs_pkg::ST_UNLOCKED;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign primary_clock_out = s.primary;
  assign phase_shifted_clock_out = s.shifted;
  assign secondary_divided_clock_out = s.sec_a;
  assign secondary_divided_clock_out_b = s.sec_b;
  assign cascade_clock_out = s.cascade_out;
  assign lock = s.lock;
  assign irq = s.irq;

  // assertions
  a_lock_after_change: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && s.pready && paddr == pcs_pkg::ADDR_DIV) |=> !lock)
    else $error("lock held after divider write");
  a_lock_from_state: assert property (@(posedge pclk) disable iff (!presetn)
    lock |-> $past(s.lock_st == pcs_pkg::ST_LOCKED))
    else $error("lock without locked state");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(lock) ##1 (s.irq_en[0])) |-> irq)
    else $error("lock gain irq missing");
  a_phase_static: assert property (@(posedge pclk) disable iff (!presetn)
    (!s.ctrl[pcs_pkg::CTRL_DYN_MODE] && $stable(s.ctrl)) |=> s.phase_act == $past(s.phase_cfg))
    else $error("static phase not applied");
  a_phase_dyn: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[pcs_pkg::CTRL_DYN_MODE] && $stable(s.ctrl)) |=> s.phase_act == $past(s.phase_dyn))
    else $error("dynamic phase not applied");
  a_dyn_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (s.phase_act != $past(s.phase_act)) |-> !lock)
    else $error("lock kept across phase change");
  a_shift_tap: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(s.phase_act) |=> phase_shifted_clock_out == $past(s.shift_line[s.phase_act.coarse]))
    else $error("coarse tap wrong");
  a_primary_div: assert property (@(posedge pclk) disable iff (!presetn)
    (s.op_cnt < s.div.out_div && $stable(s.div)) |=> $stable(primary_clock_out))
    else $error("primary toggled early");
  a_ref_tick: assert property (@(posedge pclk) disable iff (!presetn)
    s.ref_tick |-> $past(s.ref_s2 && !s.ref_d))
    else $error("divider tick without edge");
endmodule : pcs_pll_ctrl

`default_nettype wire

// ### bench/pcs_fabric_model.sv
// fabric-side model: reference source, user feedback loop and dynamic phase drive
`timescale 1ns/1ns
`default_nettype none
module pcs_fabric_model #(
  parameter int HALF = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commanded steps, fine in the upper nibble
  input wire logic [7:0] dyn_set,
  // towards the block
  output logic reference_clock_in,
  output logic feedback_clock_in,
  output logic [3:0] dyn_fine_steps,
  output logic [3:0] dyn_coarse_steps
);
  int cnt = 0;
  logic ref_q = 1'b0;
  logic [7:0] dyn_q = 8'h00;
  // a source oscillator runs free, it is not a framed link
  always @(posedge pclk) begin
    if (!presetn) begin
      cnt <= 0;
      ref_q <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ref_q <= ~ref_q;
    end else begin
      cnt <= cnt + 1;
    end
    dyn_q <= dyn_set;
  end
  assign reference_clock_in = ref_q;
  // user feedback pin looped straight back, so the two paths can agree
  assign feedback_clock_in = ref_q;
  assign dyn_fine_steps = dyn_q[7:4];
  assign dyn_coarse_steps = dyn_q[3:0];
endmodule : pcs_fabric_model
`default_nettype wire

// ### bench/pcs_pll_ctrl_bench.sv
// self-checking bench for the clock synthesis control block
`timescale 1ns/1ns
`default_nettype none
module pcs_pll_ctrl_bench;
  localparam int LW = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, ref_clk, fb_clk, prim, shf, seca, secb, casc, lock, irq, e;
  logic [3:0] fine, coarse;
  logic [7:0] dyn = 8'h00;
  logic [7:0] seed = 8'h5f;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int c, t0, tp, tc, ta, sm;
  int t_lock = 0;
  logic lk_q = 1'b0;
  int mdl [7] = '{0, 1, 0, 0, 0, 0, 0};
  int msk [7] = '{32'h1f, -1, 32'hff, 0, 0, 3, 0};

  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // cycle of each lock rise, taken where lock has settled
  always @(negedge pclk) begin
    if (lock === 1'b1 && lk_q !== 1'b1) t_lock = cyc;
    lk_q = lock;
  end

  pcs_pll_ctrl #(.LOCK_WAIT(LW)) u_pcs_pll_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reference_clock_in(ref_clk), .feedback_clock_in(fb_clk),
    .osc_in(1'b0), .dyn_fine_steps(fine), .dyn_coarse_steps(coarse), .primary_clock_out(prim),
    .phase_shifted_clock_out(shf), .secondary_divided_clock_out(seca),
    .secondary_divided_clock_out_b(secb), .cascade_clock_out(casc), .lock(lock), .irq(irq));
  pcs_fabric_model u_pcs_fabric_model (.pclk(pclk), .presetn(presetn), .dyn_set(dyn),
    .reference_clock_in(ref_clk), .feedback_clock_in(fb_clk), .dyn_fine_steps(fine),
    .dyn_coarse_steps(coarse));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // writes at 0x1c and above leave the model alone
    if (w && a < 8'h1c) mdl[a >> 2] = d & msk[a >> 2];
  endtask : apb

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk("register", mdl[a >> 2], r);
  endtask : rd

  task automatic wait_lock();
    c = 0;
    while (lock !== 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    chk("lock", 1, lock);
  endtask : wait_lock

  // counts edges at the falling clock so the registered outputs have settled
  task automatic count_tog(input int fs, input int cs);
    logic lp, lc, la;
    logic hp [$];
    logic ha [$];
    int n;
    tp = 0;
    tc = 0;
    ta = 0;
    sm = 0;
    @(negedge pclk);
    lp = prim;
    lc = casc;
    la = seca;
    hp.push_back(prim);
    ha.push_back(seca);
    repeat (48) begin
      @(negedge pclk);
      tp += int'(prim !== lp);
      tc += int'(casc !== lc);
      ta += int'(seca !== la);
      hp.push_back(prim);
      ha.push_back(seca);
      n = hp.size();
      // shifted: primary late by the coarse tap plus two register stages
      if (n > cs + 2) sm += int'(shf !== hp[n - 3 - cs]);
      // second secondary: fine tap of the line folded onto the divided clock
      if (n > fs + 2) sm += int'(secb !== (hp[n - 3 - fs] ^ ha[n - 2]));
      lp = prim;
      lc = casc;
      la = seca;
    end
  endtask : count_tog

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 7; a++) rd(8'(a * 4));
    apb(1'b1, 8'h1c, 32'hffffffff);
    chk("pslverr", 1, e);
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", 1, e);
    seed = lfsr(seed);
    apb(1'b1, pcs_pkg::ADDR_CTRL, 32'h2);
    apb(1'b1, pcs_pkg::ADDR_IRQ_EN, 32'h3);
    apb(1'b1, pcs_pkg::ADDR_PHASE, {24'h0, seed});
    wait_lock();
    for (int a = 0; a < 3; a++) rd(8'(a * 4));
    rd(pcs_pkg::ADDR_IRQ_EN);
    apb(1'b0, pcs_pkg::ADDR_STATUS, 32'h0);
    chk("status", {20'h0, seed, 4'h1}, r);
    apb(1'b0, pcs_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 1, r);
    chk("irq", 1, irq);
    apb(1'b1, pcs_pkg::ADDR_IRQ_CLR, 32'h1);
    apb(1'b0, pcs_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 0, r);
    chk("irq", 0, irq);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, pcs_pkg::ADDR_DIV, 32'h1 | (d << 8));
      t0 = cyc;
      apb(1'b0, pcs_pkg::ADDR_STATUS, 32'h0);
      chk("lock bit", 0, r[0]);
      count_tog(int'(seed[7:4]), int'(seed[3:0]));
      chk("primary rate", 1, tp >= 48 / (d + 1) - 1 && tp <= 48 / (d + 1) + 1);
      chk("secondary rate", 1, ta >= 12 / (d + 1) - 1 && ta <= 12 / (d + 1) + 1);
      chk("shifted taps", 0, sm);
      chk("cascade rate", 1, tc >= tp - 1 && tc <= tp + 1);
      wait_lock();
      chk("relock time", 1, t_lock - t0 >= LW);
      apb(1'b0, pcs_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("irq status", 3, r);
      apb(1'b1, pcs_pkg::ADDR_IRQ_CLR, 32'h3);
    end
    seed = lfsr(seed);
    dyn <= seed;
    apb(1'b1, pcs_pkg::ADDR_CTRL, 32'ha);
    apb(1'b0, pcs_pkg::ADDR_STATUS, 32'h0);
    chk("dynamic phase", {20'h0, seed, 4'h0}, r);
    wait_lock();
    seed = lfsr(seed);
    dyn <= seed;
    repeat (4) @(posedge pclk);
    apb(1'b0, pcs_pkg::ADDR_STATUS, 32'h0);
    chk("dynamic step", {20'h0, seed, 4'h0}, r);
    wrap_up();
  end
endmodule : pcs_pll_ctrl_bench
`default_nettype wire
